// ==== ssso_defs.svh ====
`ifndef SSSO_DEFS_SVH
`define SSSO_DEFS_SVH

// register byte offsets
`define SSSO_OFS_THRESH      8'h00
`define SSSO_OFS_ALLOC       8'h04
`define SSSO_OFS_STATUS      8'h08
`define SSSO_OFS_INT_STAT    8'h0c
`define SSSO_OFS_INT_MASK    8'h10

// alloc register fields
`define SSSO_ALLOC_SPD_LSB   0
`define SSSO_ALLOC_RDY_LSB   2
`define SSSO_ALLOC_SON_BIT   4
`define SSSO_ALLOC_ABS_BIT   5

// reset values and threshold write limits
`define SSSO_THRESH_RST      14'h0014
`define SSSO_THRESH_MIN      14'h0001
`define SSSO_THRESH_MAX      14'h2710
`define SSSO_SPD_ALLOC_RST   2'h1
`define SSSO_RDY_ALLOC_RST   2'h2

// timing
`define SSSO_CLK_PERIOD_NS   100
`define SSSO_GLITCH_NS       500000
`define SSSO_MISMATCH_MS     10000

`endif

// ==== ssso_pkg.sv ====
package ssso_pkg;

  typedef enum logic [2:0] {
    SSSO_SAFE_OFF  = 3'b001,
    SSSO_BASEBLOCK = 3'b010,
    SSSO_RUN       = 3'b100
  } ssso_state_t;

  typedef struct packed {
    logic        abs_encoder_fitted;
    logic        servo_on_alloc;
    logic [1:0]  ready_alloc;
    logic [1:0]  speed_reached_alloc;
  } ssso_alloc_t;

  typedef struct packed {
    logic        run;
    logic        ready;
    logic        speed_reached;
    logic        timing_alarm;
    logic        ch2_on;
    logic        ch1_on;
    ssso_state_t state;
  } ssso_status_t;

  typedef struct packed {
    logic        ready_rise;
    logic        speed_rise;
    logic        safe_off_entry;
    logic        timing_alarm;
  } ssso_irq_t;

endpackage : ssso_pkg

// ==== ssso_top.sv ====
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
`include "ssso_defs.svh"
module ssso_top #(
  parameter int GLITCH_CYC   = `SSSO_GLITCH_NS / `SSSO_CLK_PERIOD_NS,
  parameter int MISMATCH_CYC = `SSSO_MISMATCH_MS * (1000000 / `SSSO_CLK_PERIOD_NS),
  parameter int SPEED_W      = 14,
  parameter int N_TERM       = 3
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic [31:0]             hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic               safe_off_ch1,
  input  wire logic               safe_off_ch2,
  input  wire logic               servo_on_in,
  input  wire logic               encoder_enable_in,
  input  wire logic               main_power_in,
  input  wire logic               alarm_reset_in,
  input  wire logic               other_alarm_in,
  input  wire logic               abs_xfer_done_in,
  input  wire logic [SPEED_W-1:0] motor_speed,
  output logic [N_TERM-1:0]       term_out,
  output logic                    power_stage_run,
  output logic                    safe_off_state,
  output logic                    baseblock_state,
  output logic                    safety_input_timing_alarm,
  output logic                    irq
);

  localparam int GW = $clog2(GLITCH_CYC + 1);
  localparam int MW = $clog2(MISMATCH_CYC + 1);
  localparam int NP = 6;

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // a level is taken only when stages two and three agree
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] s1_ff;
  logic [NP-1:0] s2_ff;
  logic [NP-1:0] s3_ff;
  logic [NP-1:0] pin_ff;

  assign pin_raw = {alarm_reset_in, main_power_in, encoder_enable_in,
                    servo_on_in, safe_off_ch2, safe_off_ch1};

  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_sync
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          s1_ff[gi]  <= 1'b0;
          s2_ff[gi]  <= 1'b0;
          s3_ff[gi]  <= 1'b0;
          pin_ff[gi] <= 1'b0;
        end else begin
          s1_ff[gi] <= pin_raw[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          if (s2_ff[gi] == s3_ff[gi]) begin
            pin_ff[gi] <= s3_ff[gi];
          end
        end
      end
    end
  endgenerate

  logic servo_on_s;
  logic enc_en_s;
  logic main_pwr_s;
  logic alm_rst_s;
  assign servo_on_s = pin_ff[2];
  assign enc_en_s   = pin_ff[3];
  assign main_pwr_s = pin_ff[4];
  assign alm_rst_s  = pin_ff[5];

  // ------------------------------------------------------------
  // safe-off channel glitch filter
  // ------------------------------------------------------------
  // closed input reads high and counts as on; an off level has to
  // outlast the glitch window before the channel is taken as off
  logic [1:0]    ch_on_ff;
  logic [GW-1:0] glitch_cnt_ff [2];

  generate
    for (gi = 0; gi < 2; gi++) begin : g_filt
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          ch_on_ff[gi]      <= 1'b0;
          glitch_cnt_ff[gi] <= '0;
        end else if (pin_ff[gi]) begin
          ch_on_ff[gi]      <= 1'b1;
          glitch_cnt_ff[gi] <= '0;
        end else if (ch_on_ff[gi]) begin
          if (glitch_cnt_ff[gi] == GW'(GLITCH_CYC)) begin
            ch_on_ff[gi] <= 1'b0;
          end else begin
            glitch_cnt_ff[gi] <= glitch_cnt_ff[gi] + GW'(1);
          end
        end
      end
    end
  endgenerate

  logic both_on;
  assign both_on = ch_on_ff[0] & ch_on_ff[1];

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [13:0]        thresh_ff;
  ssso_pkg::ssso_alloc_t alloc_ff;
  ssso_pkg::ssso_irq_t   int_stat_ff;
  ssso_pkg::ssso_irq_t   int_mask_ff;
  logic               wr_pend_ff;
  logic [7:0]         wr_addr_ff;

  logic addr_ok;
  assign addr_ok = hsel & hready & htrans[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      if (hready) begin
        wr_pend_ff <= addr_ok & hwrite & (haddr[31:8] == 24'h000000);
      end
      if (addr_ok) begin
        wr_addr_ff <= haddr[7:0];
      end
    end
  end

  logic wr_thresh;
  logic wr_alloc;
  logic wr_istat;
  logic wr_imask;
  assign wr_thresh = wr_pend_ff & (wr_addr_ff == `SSSO_OFS_THRESH);
  assign wr_alloc  = wr_pend_ff & (wr_addr_ff == `SSSO_OFS_ALLOC);
  assign wr_istat  = wr_pend_ff & (wr_addr_ff == `SSSO_OFS_INT_STAT);
  assign wr_imask  = wr_pend_ff & (wr_addr_ff == `SSSO_OFS_INT_MASK);

  // out-of-range threshold writes are dropped, keeping the old value
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thresh_ff <= `SSSO_THRESH_RST;
    end else if (wr_thresh && hwdata[31:14] == 18'h00000 &&
                 hwdata[13:0] >= `SSSO_THRESH_MIN &&
                 hwdata[13:0] <= `SSSO_THRESH_MAX) begin
      thresh_ff <= hwdata[13:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alloc_ff.speed_reached_alloc <= `SSSO_SPD_ALLOC_RST;
      alloc_ff.ready_alloc         <= `SSSO_RDY_ALLOC_RST;
      alloc_ff.servo_on_alloc      <= 1'b0;
      alloc_ff.abs_encoder_fitted  <= 1'b0;
    end else if (wr_alloc) begin
      alloc_ff.speed_reached_alloc <= hwdata[`SSSO_ALLOC_SPD_LSB +: 2];
      alloc_ff.ready_alloc         <= hwdata[`SSSO_ALLOC_RDY_LSB +: 2];
      alloc_ff.servo_on_alloc      <= hwdata[`SSSO_ALLOC_SON_BIT];
      alloc_ff.abs_encoder_fitted  <= hwdata[`SSSO_ALLOC_ABS_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_mask_ff <= '0;
    end else if (wr_imask) begin
      int_mask_ff <= hwdata[3:0];
    end
  end

  // ------------------------------------------------------------
  // safe-off state machine
  // ------------------------------------------------------------
  ssso_pkg::ssso_state_t state_ff;
  ssso_pkg::ssso_state_t nxt_state;
  logic                  alarm_ff;
  logic                  servo_on_eff;
  logic                  ready_ff;
  logic                  abs_done_ff;
  logic                  spd_ff;

  // a permanently enabled servo-on never reads as off, so safe-off is
  // never left; software must not pick that allocation here
  assign servo_on_eff = alloc_ff.servo_on_alloc | servo_on_s;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ssso_pkg::SSSO_SAFE_OFF: begin
        // servo-on must be seen off after both channels return, whether
        // or not main power is up
        if (both_on && !servo_on_eff) begin
          nxt_state = ssso_pkg::SSSO_BASEBLOCK;
        end
      end
      ssso_pkg::SSSO_BASEBLOCK: begin
        if (!both_on) begin
          nxt_state = ssso_pkg::SSSO_SAFE_OFF;
        end else if (servo_on_eff && ready_ff) begin
          nxt_state = ssso_pkg::SSSO_RUN;
        end
      end
      ssso_pkg::SSSO_RUN: begin
        if (!both_on) begin
          nxt_state = ssso_pkg::SSSO_SAFE_OFF;
        end else if (!servo_on_eff || alarm_ff || other_alarm_in) begin
          nxt_state = ssso_pkg::SSSO_BASEBLOCK;
        end
      end
      default: begin
        nxt_state = ssso_pkg::SSSO_SAFE_OFF;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= ssso_pkg::SSSO_SAFE_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ------------------------------------------------------------
  // channel mismatch alarm
  // ------------------------------------------------------------
  logic [MW-1:0] mis_cnt_ff;
  logic          alm_rst_d_ff;
  logic          alarm_set;

  assign alarm_set = (ch_on_ff[0] != ch_on_ff[1]) &&
                     (mis_cnt_ff == MW'(MISMATCH_CYC - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mis_cnt_ff <= '0;
    end else if (ch_on_ff[0] == ch_on_ff[1]) begin
      mis_cnt_ff <= '0;
    end else if (!alarm_set) begin
      mis_cnt_ff <= mis_cnt_ff + MW'(1);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alm_rst_d_ff <= 1'b0;
    end else begin
      alm_rst_d_ff <= alm_rst_s;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alarm_ff <= 1'b0;
    end else if (alarm_set) begin
      alarm_ff <= 1'b1;
    end else if (alm_rst_s && !alm_rst_d_ff &&
                 ch_on_ff[0] == ch_on_ff[1]) begin
      alarm_ff <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // speed reached, ready, run
  // ------------------------------------------------------------
  logic [SPEED_W-1:0] thresh_ext;
  assign thresh_ext = SPEED_W'(thresh_ff);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spd_ff <= 1'b0;
    end else begin
      spd_ff <= (motor_speed >= thresh_ext);
    end
  end

  // absolute data handed over only counts while encoder enable stays high
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      abs_done_ff <= 1'b0;
    end else if (!enc_en_s) begin
      abs_done_ff <= 1'b0;
    end else if (abs_xfer_done_in) begin
      abs_done_ff <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_ff <= 1'b0;
    end else begin
      ready_ff <= main_pwr_s && both_on && !alarm_ff && !other_alarm_in &&
                  nxt_state != ssso_pkg::SSSO_SAFE_OFF &&
                  (!alloc_ff.abs_encoder_fitted ||
                   (enc_en_s && abs_done_ff));
    end
  end

  // each channel gates the run flop on its own; the power stage drops
  // one edge after the filter declares a channel off, far inside 20 ms
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      power_stage_run <= 1'b0;
    end else begin
      power_stage_run <= ch_on_ff[0] & ch_on_ff[1] & ~alarm_ff &
                         (nxt_state == ssso_pkg::SSSO_RUN);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      safe_off_state            <= 1'b1;
      baseblock_state           <= 1'b0;
      safety_input_timing_alarm <= 1'b0;
    end else begin
      safe_off_state            <= (nxt_state == ssso_pkg::SSSO_SAFE_OFF);
      baseblock_state           <= (nxt_state == ssso_pkg::SSSO_BASEBLOCK);
      safety_input_timing_alarm <= alarm_ff | alarm_set;
    end
  end

  // ------------------------------------------------------------
  // output terminal allocation
  // ------------------------------------------------------------
  // allocation code 0 disconnects; code n drives terminal n-1
  generate
    for (gi = 0; gi < N_TERM; gi++) begin : g_term
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          term_out[gi] <= 1'b0;
        end else begin
          term_out[gi] <=
            (spd_ff && alloc_ff.speed_reached_alloc == 2'(gi + 1)) ||
            (ready_ff && alloc_ff.ready_alloc == 2'(gi + 1));
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // interrupts
  // ------------------------------------------------------------
  logic                spd_d_ff;
  logic                rdy_d_ff;
  logic                so_d_ff;
  ssso_pkg::ssso_irq_t ev;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spd_d_ff <= 1'b0;
      rdy_d_ff <= 1'b0;
      so_d_ff  <= 1'b1;
    end else begin
      spd_d_ff <= spd_ff;
      rdy_d_ff <= ready_ff;
      so_d_ff  <= safe_off_state;
    end
  end

  assign ev.timing_alarm   = alarm_set;
  assign ev.safe_off_entry = safe_off_state & ~so_d_ff;
  assign ev.speed_rise     = spd_ff & ~spd_d_ff;
  assign ev.ready_rise     = ready_ff & ~rdy_d_ff;

  // a new event wins over a write-one clear in the same cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_stat_ff <= '0;
    end else begin
      int_stat_ff <= (int_stat_ff & ~({4{wr_istat}} & hwdata[3:0])) | ev;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat_ff & int_mask_ff);
    end
  end

  // ------------------------------------------------------------
  // ahb read side
  // ------------------------------------------------------------
  ssso_pkg::ssso_status_t status;
  assign status = '{run: power_stage_run, ready: ready_ff,
                    speed_reached: spd_ff, timing_alarm: alarm_ff,
                    ch2_on: ch_on_ff[1], ch1_on: ch_on_ff[0],
                    state: state_ff};

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    case (haddr[7:0])
      `SSSO_OFS_THRESH:   rd_mux = {18'h00000, thresh_ff};
      `SSSO_OFS_ALLOC:    rd_mux = {26'h0000000, alloc_ff};
      `SSSO_OFS_STATUS:   rd_mux = {23'h000000, status};
      `SSSO_OFS_INT_STAT: rd_mux = {28'h0000000, int_stat_ff};
      `SSSO_OFS_INT_MASK: rd_mux = {28'h0000000, int_mask_ff};
      default:            rd_mux = 32'h00000000;
    endcase
  end

  // zero-wait slave: read data is captured in the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addr_ok && !hwrite && haddr[31:8] == 24'h000000) begin
        hrdata <= rd_mux;
      end else if (addr_ok) begin
        hrdata <= 32'h00000000;
      end
    end
  end

endmodule : ssso_top

// ==== ssso_far_side.sv ====
`timescale 1ns/1ps
module ssso_far_side #(
  parameter int DONE_DLY = 30
) (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       guard_open,
  input  wire logic [1:0] ch_hold,
  input  wire logic       son_req,
  input  wire logic       enc_req,
  output logic            safe_off_ch1,
  output logic            safe_off_ch2,
  output logic            servo_on_in,
  output logic            encoder_enable_in,
  output logic            abs_xfer_done_in
);
  logic [7:0] xfer_cnt_ff;
  // ----
  // safety unit
  // ----
  // one guard contact opens both channels; ch_hold models a welded contact
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      safe_off_ch1 <= 1'b1;
      safe_off_ch2 <= 1'b1;
    end else begin
      safe_off_ch1 <= !guard_open || ch_hold[0];
      safe_off_ch2 <= !guard_open || ch_hold[1];
    end
  end
  // ----
  // host controller
  // ----
  // absolute data takes DONE_DLY cycles once the encoder is enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      servo_on_in       <= 1'b0;
      encoder_enable_in <= 1'b0;
      abs_xfer_done_in  <= 1'b0;
      xfer_cnt_ff       <= 8'h00;
    end else begin
      servo_on_in       <= son_req;
      encoder_enable_in <= enc_req;
      if (!enc_req) begin
        xfer_cnt_ff      <= 8'h00;
        abs_xfer_done_in <= 1'b0;
      end else if (xfer_cnt_ff == 8'(DONE_DLY)) begin
        abs_xfer_done_in <= 1'b1;
      end else begin
        xfer_cnt_ff <= xfer_cnt_ff + 8'h01;
      end
    end
  end
endmodule : ssso_far_side

// ==== ssso_top_asserts.sv ====
`timescale 1ns/1ps
module ssso_top_asserts #(
  parameter int GLITCH_CYC   = 8,
  parameter int MISMATCH_CYC = 50
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic safe_off_ch1,
  input wire logic safe_off_ch2,
  input wire logic servo_on_in,
  input wire logic alarm_reset_in,
  input wire logic power_stage_run,
  input wire logic safe_off_state,
  input wire logic baseblock_state,
  input wire logic safety_input_timing_alarm
);
  // ----
  // helper counters
  // ----
  // margins cover the pin synchroniser plus the filter pipeline
  localparam int OFF_LIM = GLITCH_CYC + 8;
  localparam int ALM_LIM = MISMATCH_CYC + GLITCH_CYC + 12;
  logic [31:0] off_cnt_ff;
  logic [31:0] mis_cnt_ff;
  logic [31:0] since_long_ff;
  logic [31:0] son_hi_ff;
  logic [31:0] since_rst_ff;
  logic        arst_d_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      off_cnt_ff    <= '0;
      mis_cnt_ff    <= '0;
      since_long_ff <= 32'h0000ffff;
      son_hi_ff     <= '0;
      since_rst_ff  <= 32'h0000ffff;
      arst_d_ff     <= 1'b0;
    end else begin
      off_cnt_ff    <= (safe_off_ch1 && safe_off_ch2) ? '0 : off_cnt_ff + 1;
      mis_cnt_ff    <= (safe_off_ch1 != safe_off_ch2) ? mis_cnt_ff + 1 : '0;
      since_long_ff <= (off_cnt_ff > GLITCH_CYC) ? '0 : since_long_ff + 1;
      son_hi_ff     <= servo_on_in ? son_hi_ff + 1 : '0;
      arst_d_ff     <= alarm_reset_in;
      since_rst_ff  <= (alarm_reset_in && !arst_d_ff) ? '0 : since_rst_ff + 1;
    end
  end
  // ----
  // properties
  // ----
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_chan_dropped;
    off_cnt_ff == OFF_LIM;
  endsequence
  sequence s_left_safe_off;
    $fell(safe_off_state);
  endsequence

  a_run_off_deadline: assert property (
    s_chan_dropped |-> !power_stage_run && safe_off_state)
    else $error("run still on after channel off");
  a_glitch_ignored: assert property (
    $rose(safe_off_state) |-> since_long_ff <= 10)
    else $error("safe-off entered on a short pulse");
  a_run_excludes: assert property (
    power_stage_run |-> !safe_off_state && !baseblock_state && !safety_input_timing_alarm)
    else $error("run together with a stop state");
  a_run_leaves_to: assert property (
    $fell(power_stage_run) |-> safe_off_state ^ baseblock_state)
    else $error("run dropped into no stop state");
  a_exit_to_bb: assert property (
    s_left_safe_off |-> baseblock_state && son_hi_ff < 6 && off_cnt_ff == 0)
    else $error("safe-off left with servo on or channel off");
  a_alarm_in_time: assert property (
    mis_cnt_ff == ALM_LIM |-> safety_input_timing_alarm)
    else $error("channel mismatch alarm missing");
  a_alarm_not_early: assert property (
    $rose(safety_input_timing_alarm) |-> mis_cnt_ff >= MISMATCH_CYC)
    else $error("channel mismatch alarm too early");
  a_alarm_latched: assert property (
    $fell(safety_input_timing_alarm) |-> since_rst_ff <= 8 && mis_cnt_ff == 0)
    else $error("alarm cleared without a valid alarm reset");
endmodule : ssso_top_asserts

bind ssso_top ssso_top_asserts #(
  .GLITCH_CYC(GLITCH_CYC), .MISMATCH_CYC(MISMATCH_CYC)
) u_ssso_top_asserts (
  .hclk(hclk), .hresetn(hresetn), .safe_off_ch1(safe_off_ch1),
  .safe_off_ch2(safe_off_ch2), .servo_on_in(servo_on_in),
  .alarm_reset_in(alarm_reset_in), .power_stage_run(power_stage_run),
  .safe_off_state(safe_off_state), .baseblock_state(baseblock_state),
  .safety_input_timing_alarm(safety_input_timing_alarm)
);

// ==== test_servo_status_and_safe_off.sv ====
`timescale 1ns/1ps
`include "ssso_defs.svh"
module test_servo_status_and_safe_off;
  localparam int GC = 8;
  localparam int MC = 50;
  localparam logic [31:0] A_TH = {24'h0, `SSSO_OFS_THRESH};
  localparam logic [31:0] A_AL = {24'h0, `SSSO_OFS_ALLOC};
  localparam logic [31:0] A_ST = {24'h0, `SSSO_OFS_STATUS};
  localparam logic [31:0] A_IS = {24'h0, `SSSO_OFS_INT_STAT};
  localparam logic [31:0] A_IM = {24'h0, `SSSO_OFS_INT_MASK};
  typedef struct packed {
    logic [31:0] wr;
    logic [31:0] keep;
    logic [13:0] spd;
    logic        hit;
  } ssso_row_t;
  ssso_row_t   rows [8];
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic        main_power_in, alarm_reset_in, other_alarm_in, guard_open;
  logic        son_req, enc_req, safe_off_ch1, safe_off_ch2, servo_on_in;
  logic        encoder_enable_in, abs_xfer_done_in, power_stage_run;
  logic        safe_off_state, baseblock_state, safety_input_timing_alarm;
  logic [1:0]  htrans, ch_hold, ra, sa;
  logic [2:0]  hsize, term_out, te;
  logic [13:0] motor_speed;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          num_errors, checks;

  assign hready = hreadyout;
  ssso_top #(.GLITCH_CYC(GC), .MISMATCH_CYC(MC)) u_ssso_top (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .safe_off_ch1, .safe_off_ch2, .servo_on_in,
    .encoder_enable_in, .main_power_in, .alarm_reset_in, .other_alarm_in,
    .abs_xfer_done_in, .motor_speed, .term_out, .power_stage_run, .safe_off_state,
    .baseblock_state, .safety_input_timing_alarm, .irq
  );
  ssso_far_side #(.DONE_DLY(30)) u_ssso_far_side (
    .hclk, .hresetn, .guard_open, .ch_hold, .son_req, .enc_req, .safe_off_ch1,
    .safe_off_ch2, .servo_on_in, .encoder_enable_in, .abs_xfer_done_in
  );
  // ----
  // tasks
  // ----
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge hclk);
  endtask : cyc
  task bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus
  task wr(input logic [31:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task rdc(input string nm, input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(nm, rd, exp);
    chk("hresp", hresp, 32'h0);
  endtask : rdc
  task reset_check();
    chk("safe_off_state", safe_off_state, 32'h1);
    chk("run", power_stage_run, 32'h0);
    chk("irq", irq, 32'h0);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc("thresh", A_TH, `SSSO_THRESH_RST);
    rdc("alloc", A_AL, 32'h9);
    rdc("mask", A_IM, 32'h0);
    rdc("unmapped", 32'h14, 32'h0);
    rdc("high addr", 32'h100, 32'h0);
    wr(32'h100, 32'h64);
    rdc("high addr write", A_TH, `SSSO_THRESH_RST);
  endtask : reset_check
  task end_sim();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  // ----
  // stimulus
  // ----
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    end_sim();
  end
  initial begin
    hresetn = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'b00; hwrite = 1'b0;
    hsize = 3'b010; hwdata = '0; main_power_in = 1'b1; alarm_reset_in = 1'b0;
    other_alarm_in = 1'b0; motor_speed = '0; guard_open = 1'b0; ch_hold = 2'b00;
    son_req = 1'b0; enc_req = 1'b0; num_errors = 0; checks = 0;
    rows = '{'{32'h14, 32'h14, 14'h13, 1'b0}, '{32'h14, 32'h14, 14'h14, 1'b1},
             '{32'h1, 32'h1, 14'h0, 1'b0}, '{32'h1, 32'h1, 14'h1, 1'b1},
             '{32'h2710, 32'h2710, 14'h270f, 1'b0}, '{32'h2710, 32'h2710, 14'h2710, 1'b1},
             '{32'h0, 32'h2710, 14'h2710, 1'b1}, '{32'h2711, 32'h2710, 14'h270f, 1'b0}};
    repeat (20) @(posedge hclk);
    reset_check();
    cyc(24);
    chk("baseblock", baseblock_state, 32'h1);
    rdc("status", A_ST, 32'h9a);
    for (int i = 0; i < 8; i++) begin
      wr(A_TH, rows[i].wr);
      motor_speed <= rows[i].spd;
      rdc("thresh", A_TH, rows[i].keep);
      cyc(3);
      chk("speed_reached", term_out[0], rows[i].hit);
    end
    son_req <= 1'b1;
    cyc(24);
    chk("run", power_stage_run, 32'h1);
    guard_open <= 1'b1;
    cyc(GC);
    guard_open <= 1'b0;
    cyc(24);
    chk("run after pulse", power_stage_run, 32'h1);
    rdc("int_stat", A_IS, 32'hc);
    wr(A_IS, 32'hf);
    wr(A_IM, 32'h2);
    for (int i = 0; i < 2; i++) begin
      main_power_in <= (i == 0);
      ch_hold <= (i == 0) ? 2'b01 : 2'b10;
      guard_open <= 1'b1;
      cyc(GC + 12);
      chk("safe_off_state", safe_off_state, 32'h1);
      chk("run", power_stage_run, 32'h0);
      chk("irq", irq, 32'h1);
      wr(A_IS, 32'h2);
      cyc(2);
      chk("irq cleared", irq, 32'h0);
      guard_open <= 1'b0;
      ch_hold <= 2'b00;
      cyc(24);
      chk("held in safe-off", safe_off_state, 32'h1);
      son_req <= 1'b0;
      cyc(24);
      chk("baseblock", baseblock_state, 32'h1);
      son_req <= 1'b1;
      main_power_in <= 1'b1;
      cyc(24);
      chk("run", power_stage_run, 32'h1);
    end
    motor_speed <= 14'h2710;
    for (int a = 0; a < 4; a++) begin
      ra = 2'(a);
      sa = 2'(a + 1);
      te = 3'b000;
      if (ra != 2'd0) te[ra - 2'd1] = 1'b1;
      if (sa != 2'd0) te[sa - 2'd1] = 1'b1;
      wr(A_AL, {28'h0, ra, sa});
      cyc(3);
      chk("term_out", term_out, te);
    end
    wr(A_AL, 32'h9);
    main_power_in <= 1'b0;
    cyc(24);
    chk("ready no power", term_out[1], 32'h0);
    main_power_in <= 1'b1;
    other_alarm_in <= 1'b1;
    cyc(24);
    chk("ready alarm", term_out[1], 32'h0);
    other_alarm_in <= 1'b0;
    son_req <= 1'b0;
    cyc(24);
    chk("ready", term_out[1], 32'h1);
    wr(A_AL, 32'h29);
    cyc(8);
    chk("ready no encoder", term_out[1], 32'h0);
    enc_req <= 1'b1;
    cyc(20);
    chk("ready before data", term_out[1], 32'h0);
    cyc(24);
    chk("ready after data", term_out[1], 32'h1);
    wr(A_AL, 32'h19);
    guard_open <= 1'b1;
    cyc(GC + 12);
    guard_open <= 1'b0;
    cyc(24);
    chk("servo on fixed", safe_off_state, 32'h1);
    wr(A_AL, 32'h9);
    cyc(24);
    chk("baseblock", baseblock_state, 32'h1);
    wr(A_IM, 32'h1);
    ch_hold <= 2'b10;
    guard_open <= 1'b1;
    cyc(MC);
    chk("alarm early", safety_input_timing_alarm, 32'h0);
    cyc(GC + 24);
    chk("alarm", safety_input_timing_alarm, 32'h1);
    chk("irq alarm", irq, 32'h1);
    for (int k = 0; k < 2; k++) begin
      alarm_reset_in <= 1'b1;
      cyc(8);
      alarm_reset_in <= 1'b0;
      cyc(16);
      chk("alarm latched", safety_input_timing_alarm, (k == 0) ? 32'h1 : 32'h0);
      guard_open <= 1'b0;
      ch_hold <= 2'b00;
      cyc(24);
    end
    wr(A_IS, 32'h1);
    cyc(2);
    chk("irq cleared", irq, 32'h0);
    wr(A_TH, 32'h64);
    hresetn <= 1'b0;
    cyc(2);
    reset_check();
    end_sim();
  end
endmodule : test_servo_status_and_safe_off
